// *** drce_engine.v ***
// Disk read command engine with an AXI4-Lite register slave.
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "drce_regs.vh"
module drce_engine (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rstn,
  // AXI4-Lite write
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Media word source
  input  wire [15:0] media_word,
  input  wire        media_valid,
  input  wire [3:0]  media_fault,
  output reg         media_ready,
  // Busy level
  output reg         busy
);
  localparam ST_IDLE = 2'd0;
  localparam ST_XFER = 2'd1;

  reg  [1:0]  state;
  reg  [7:0]  feat_cur;
  reg  [7:0]  feat_prev;
  reg  [7:0]  cnt_cur;
  reg  [7:0]  cnt_prev;
  reg  [7:0]  num_cur;
  reg  [7:0]  num_prev;
  reg  [7:0]  cl_cur;
  reg  [7:0]  cl_prev;
  reg  [7:0]  ch_cur;
  reg  [7:0]  ch_prev;
  reg  [7:0]  devhead;
  reg  [7:0]  status;
  reg  [7:0]  error;
  reg         high_order_select;
  reg  [15:0] time_unit;
  reg  [15:0] rd_word;
  reg         word_full;
  reg  [1:0]  mode;
  reg         rc_mode;
  reg  [47:0] lba;
  reg  [16:0] remain;
  reg  [8:0]  word_cnt;
  reg  [47:0] bad_lba;
  reg  [16:0] bad_run;
  reg         bad_seen;
  reg         sec_bad;
  reg  [6:0]  us_div;
  reg  [23:0] us_left;
  reg         limit_on;
  reg  [7:0]  aw_addr;
  reg         aw_held;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg         w_held;

  wire        do_write = aw_held && w_held && !s_axi_bvalid;
  wire        wr_b0    = w_strb[0];
  wire [7:0]  wb       = w_data[7:0];
  wire [7:0]  cmd      = wb;
  wire        is_read  = ({1'b0, cmd[7:1]} == (`DRCE_CMD_READ >> 1));
  wire        take_wd  = media_valid && media_ready;
  wire        sec_end  = take_wd && (word_cnt == `DRCE_WORDS_PER_SEC - 9'd1);
  wire        word_bad = take_wd && (media_fault != 4'h0);
  wire        sec_fail = sec_bad || word_bad;
  wire        expired  = limit_on && (us_left == 24'd0);
  wire        data_pop = s_axi_arvalid && s_axi_arready && !s_axi_rvalid
                         && (s_axi_araddr == `DRCE_OFF_DATA);
  wire [16:0] last_rem = remain - 17'd1;

  // Write channel: address and data are taken independently, in any order.
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready;
      s_axi_wready  <= !w_held && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr > `DRCE_OFF_TIMEUNIT) ? 2'b10 : 2'b00;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel; data reads consume the held media word.
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'b00;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= 2'b00;
        if (s_axi_araddr == `DRCE_OFF_DATA)
          s_axi_rdata <= {16'h0, rd_word};
        else if (s_axi_araddr == `DRCE_OFF_SECCNT)
          s_axi_rdata <= {24'h0, high_order_select ? cnt_prev : cnt_cur};
        else if (s_axi_araddr == `DRCE_OFF_SECNUM)
          s_axi_rdata <= {24'h0, high_order_select ? num_prev : num_cur};
        else if (s_axi_araddr == `DRCE_OFF_CYLLO)
          s_axi_rdata <= {24'h0, high_order_select ? cl_prev : cl_cur};
        else if (s_axi_araddr == `DRCE_OFF_CYLHI)
          s_axi_rdata <= {24'h0, high_order_select ? ch_prev : ch_cur};
        else if (s_axi_araddr == `DRCE_OFF_DEVHEAD)
          s_axi_rdata <= {24'h0, devhead};
        else if (s_axi_araddr == `DRCE_OFF_ERROR)
          s_axi_rdata <= {24'h0, error};
        else if (s_axi_araddr == `DRCE_OFF_STATUS)
          s_axi_rdata <= {24'h0, status[7:4], word_full, status[2:0]};
        else if (s_axi_araddr == `DRCE_OFF_CONTROL)
          s_axi_rdata <= {24'h0, high_order_select, 7'h0};
        else if (s_axi_araddr == `DRCE_OFF_TIMEUNIT)
          s_axi_rdata <= {16'h0, time_unit};
        else if (s_axi_araddr == `DRCE_OFF_FEATURE ||
                 s_axi_araddr == `DRCE_OFF_COMMAND ||
                 s_axi_araddr == `DRCE_OFF_MEDIA)
          s_axi_rdata <= 32'h0;
        else
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'b10;
        end
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Command engine. Parameter writes while busy are dropped.
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      state <= ST_IDLE;
      {feat_cur, feat_prev, cnt_cur, cnt_prev} <= 32'h0;
      {num_cur, num_prev, cl_cur, cl_prev, ch_cur, ch_prev} <= 48'h0;
      devhead   <= 8'h00;
      status    <= `DRCE_STATUS_RESET;
      error     <= 8'h00;
      high_order_select       <= 1'b0;
      time_unit <= `DRCE_TIMEUNIT_RESET;
      rd_word   <= 16'h0;
      word_full <= 1'b0;
      mode      <= 2'd0;
      rc_mode   <= 1'b0;
      lba       <= 48'h0;
      remain    <= 17'h0;
      word_cnt  <= 9'h0;
      bad_lba   <= 48'h0;
      bad_run   <= 17'h0;
      bad_seen  <= 1'b0;
      sec_bad   <= 1'b0;
      us_div    <= 7'h0;
      us_left   <= 24'h0;
      limit_on  <= 1'b0;
      media_ready <= 1'b0;
      busy      <= 1'b0;
    end
    else
    begin
      if (do_write && wr_b0 && aw_addr == `DRCE_OFF_CONTROL)
        high_order_select <= wb[`DRCE_CTL_HOB];
      if (do_write && wr_b0 && aw_addr == `DRCE_OFF_TIMEUNIT)
        time_unit <= w_data[15:0];
      if (do_write && wr_b0 && state == ST_IDLE)
      begin
        // A byte write to a paired register pushes the old value into the previous slot; devhead has none.
        if (aw_addr == `DRCE_OFF_FEATURE)
          {feat_prev, feat_cur} <= {feat_cur, wb};
        if (aw_addr == `DRCE_OFF_SECCNT)
          {cnt_prev, cnt_cur} <= {cnt_cur, wb};
        if (aw_addr == `DRCE_OFF_SECNUM)
          {num_prev, num_cur} <= {num_cur, wb};
        if (aw_addr == `DRCE_OFF_CYLLO)
          {cl_prev, cl_cur} <= {cl_cur, wb};
        if (aw_addr == `DRCE_OFF_CYLHI)
          {ch_prev, ch_cur} <= {ch_cur, wb};
        if (aw_addr == `DRCE_OFF_DEVHEAD)
          devhead <= wb;
        if (aw_addr == `DRCE_OFF_COMMAND &&
            (is_read || cmd == `DRCE_CMD_READ_EXT ||
             cmd == `DRCE_CMD_STREAM_DMA))
        begin
          state    <= ST_XFER;
          busy     <= 1'b1;
          status   <= 8'h80;
          error    <= 8'h00;
          word_cnt <= 9'h0;
          word_full <= 1'b0;
          bad_seen <= 1'b0;
          bad_run  <= 17'h0;
          sec_bad  <= 1'b0;
          media_ready <= 1'b1;
          mode     <= is_read ? 2'd0 :
                      (cmd == `DRCE_CMD_READ_EXT) ? 2'd1 : 2'd2;
          rc_mode  <= (cmd == `DRCE_CMD_STREAM_DMA) &&
                      feat_cur[`DRCE_FT_RC];
          if (is_read)
          begin
            lba    <= {20'h0, devhead[3:0], ch_cur, cl_cur, num_cur};
            remain <= {8'h0, (cnt_cur == 8'h0), cnt_cur};
          end
          else
          begin
            lba    <= {ch_prev, cl_prev, num_prev,
                       ch_cur, cl_cur, num_cur};
            remain <= {({cnt_prev, cnt_cur} == 16'h0),
                       cnt_prev, cnt_cur};
          end
          limit_on <= (cmd == `DRCE_CMD_STREAM_DMA) &&
                      (feat_prev != 8'h0);
          us_left  <= {16'h0, feat_prev} * {8'h0, time_unit};
          us_div   <= 7'h0;
        end
        else if (aw_addr == `DRCE_OFF_COMMAND)
        begin
          status <= 8'h41;
          error  <= 8'h04;
        end
      end
      // The last word stays readable after busy drops.
      if (data_pop)
        word_full <= 1'b0;
      if (state == ST_XFER)
      begin
        if (limit_on && !expired)
        begin
          us_div <= (us_div == `DRCE_CYC_PER_US - 7'd1) ? 7'h0 :
                    us_div + 7'd1;
          if (us_div == `DRCE_CYC_PER_US - 7'd1)
            us_left <= us_left - 24'd1;
        end
        if (take_wd)
        begin
          rd_word   <= media_word;
          word_full <= rc_mode || (media_fault == 4'h0);
          media_ready <= 1'b0;
          word_cnt  <= sec_end ? 9'h0 : word_cnt + 9'd1;
          if (media_fault[0]) error[`DRCE_ER_UNC] <= 1'b1;
          if (media_fault[1]) error[`DRCE_ER_CRC] <= 1'b1;
          if (media_fault[2]) error[`DRCE_ER_IDN] <= 1'b1;
          if (media_fault[3]) error[`DRCE_ER_ABT] <= 1'b1;
          if (media_fault != 4'h0)
            sec_bad <= 1'b1;
        end
        else if (!word_full || data_pop)
          media_ready <= 1'b1;
        if (expired && rc_mode)
        begin
          state  <= ST_IDLE;
          busy   <= 1'b0;
          media_ready <= 1'b0;
          status <= 8'h60;
          error[`DRCE_ER_TIME_LIMIT_EXPIRED_FLAG] <= 1'b1;
        end
        else if (expired)
        begin
          state  <= ST_IDLE;
          busy   <= 1'b0;
          media_ready <= 1'b0;
          status <= 8'h41;
          error[`DRCE_ER_TIME_LIMIT_EXPIRED_FLAG] <= 1'b1;
        end
        else if (word_bad && !rc_mode)
        begin
          // stop at the failing sector; its word is not handed over.
          state  <= ST_IDLE;
          busy   <= 1'b0;
          media_ready <= 1'b0;
          status <= 8'h41;
          {ch_prev, cl_prev, num_prev, ch_cur, cl_cur, num_cur} <= lba;
          {cnt_prev, cnt_cur} <= remain[15:0];
        end
        else if (sec_end)
        begin
          sec_bad <= 1'b0;
          if (sec_fail && rc_mode)
          begin
            if (!bad_seen)
              bad_lba <= lba;
            bad_seen <= 1'b1;
            bad_run  <= bad_run + 17'd1;
          end
          if (last_rem == 17'h0)
          begin
            state  <= ST_IDLE;
            busy   <= 1'b0;
            media_ready <= 1'b0;
            status <= (rc_mode && (bad_seen || sec_fail)) ? 8'h60 : 8'h40;
            {cnt_prev, cnt_cur} <= 16'h0;
            if (rc_mode && (bad_seen || sec_fail))
            begin
              {ch_prev, cl_prev, num_prev, ch_cur, cl_cur, num_cur}
                <= bad_seen ? bad_lba : lba;
              {cnt_prev, cnt_cur} <= bad_run[15:0] + {15'h0, sec_fail};
            end
            else if (mode == 2'd0)
            begin
              // last transferred sector, LBA28 wraps in the bytes.
              {devhead[3:0], ch_cur, cl_cur, num_cur} <= lba[27:0];
            end
            else
              {ch_prev, cl_prev, num_prev, ch_cur, cl_cur, num_cur} <= lba;
          end
          else
          begin
            remain <= last_rem;
            lba    <= lba + 48'd1;
          end
        end
      end
    end
  end
endmodule

// *** drce_regs.vh ***
// Register offsets, field positions, reset values and timing for the read engine.
`ifndef DRCE_REGS_VH
`define DRCE_REGS_VH
`define DRCE_OFF_DATA        8'h00
`define DRCE_OFF_FEATURE     8'h04
`define DRCE_OFF_SECCNT      8'h08
`define DRCE_OFF_SECNUM      8'h0C
`define DRCE_OFF_CYLLO       8'h10
`define DRCE_OFF_CYLHI       8'h14
`define DRCE_OFF_DEVHEAD     8'h18
`define DRCE_OFF_COMMAND     8'h1C
`define DRCE_OFF_ERROR       8'h20
`define DRCE_OFF_STATUS      8'h24
`define DRCE_OFF_CONTROL     8'h28
`define DRCE_OFF_MEDIA       8'h2C
`define DRCE_OFF_TIMEUNIT    8'h30
`define DRCE_CMD_READ        8'h20
`define DRCE_CMD_READ_EXT    8'h24
`define DRCE_CMD_STREAM_DMA  8'h2A
`define DRCE_ST_BSY          7
`define DRCE_ST_RDY          6
`define DRCE_ST_SE           5
`define DRCE_ST_DRQ          3
`define DRCE_ST_ERR          0
`define DRCE_ER_CRC          7
`define DRCE_ER_UNC          6
`define DRCE_ER_IDN          4
`define DRCE_ER_ABT          2
`define DRCE_ER_TIME_LIMIT_EXPIRED_FLAG         0
`define DRCE_FT_RC           6
`define DRCE_DH_LBA          6
`define DRCE_CTL_HOB         7
`define DRCE_WORDS_PER_SEC   9'd256
`define DRCE_CYC_PER_US      7'd125
`define DRCE_STATUS_RESET    8'h40
`define DRCE_TIMEUNIT_RESET  16'h0001
`endif

// *** drce_media_model.sv ***
// Media word source that feeds the read engine, with fault injection.
`timescale 1ns/1ps
module drce_media_model (
  // Clock and controls
  input  wire         core_clk,
  input  wire         mclr,
  input  wire         slow,
  input  wire  [19:0] fault_idx,
  input  wire  [3:0]  fault_code,
  // Word stream
  input  wire         media_ready,
  output logic [15:0] media_word,
  output logic        media_valid,
  output logic [3:0]  media_fault
);
  logic [19:0] idx = 20'h00000;
  logic [15:0] last = 16'h0000;
  logic        gap = 1'b0;
  // A word is held until taken; the slow mode then idles for one cycle.
  assign media_valid = !gap;
  // An idle word shows the inverse of the last one so stale reuse is seen.
  assign media_word = gap ? ~last : (16'h5A00 ^ idx[15:0]);
  assign media_fault = (!gap && idx == fault_idx) ? fault_code : 4'h0;
  always @(posedge core_clk)
  begin
    gap <= 1'b0;
    if (mclr)
      idx <= 20'h00000;
    else if (media_valid && media_ready)
    begin
      idx <= idx + 20'h00001;
      last <= media_word;
      gap <= slow;
    end
  end
endmodule

// *** drce_engine_checker.sv ***
// Checker of bus answers and busy reporting at the read engine's ports.
`timescale 1ns/1ps
module drce_engine_checker (
  // Clock and reset
  input wire        core_clk,
  input wire        rstn,
  // Write channels
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  // Read channels
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // Command state
  input wire        busy
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_rd_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  a_wr_answer: assert property (wr_taken |-> ##[1:4] s_axi_bvalid)
    else $error("write answer late");
  a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("second write answer");
  a_bad_addr: assert property (rd_taken ##0 s_axi_araddr > 8'h30
    |=> s_axi_rresp == 2'b10) else $error("unmapped read not refused");
  a_word_width: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("wide word");
  a_busy_status: assert property (
    rd_taken ##0 s_axi_araddr == 8'h24 |=> s_axi_rdata[7] == $past(busy))
    else $error("busy bit differs from busy port");
endmodule

bind drce_engine drce_engine_checker u_drce_engine_checker (
  .core_clk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .busy
);

// *** tb_disk_read_command_engine.sv ***
// Self-checking bench for the disk read command engine.
`timescale 1ns/1ps
`include "drce_regs.vh"
module tb_disk_read_command_engine;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic [15:0] media_word;
  logic        media_valid;
  logic [3:0]  media_fault;
  logic        media_ready;
  logic        busy;
  logic        mclr = 1'b0;
  logic        slow = 1'b0;
  logic [19:0] fault_idx = 20'hFFFFF;
  logic [3:0]  fault_code = 4'h0;
  logic [1:0]  resp;
  int          error_cnt = 0;
  int          samples_checked = 0;

  always #4 core_clk = ~core_clk;

  drce_engine u_drce_engine (
    .core_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .media_word, .media_valid, .media_fault, .media_ready, .busy
  );
  drce_media_model u_drce_media_model (
    .core_clk, .mclr, .slow, .fault_idx, .fault_code, .media_ready,
    .media_word, .media_valid, .media_fault
  );

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // A bound that runs out is itself a mismatch and ends the run.
  task automatic tmo(input int n);
    if (n >= 400)
    begin
      chk(32'h1, 32'h0);
      wrap_up;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid)
      begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    while ((s_axi_awvalid || s_axi_wvalid || s_axi_bready) && n < 400);
    tmo(n);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rready && s_axi_rvalid)
      begin
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
    while ((s_axi_arvalid || s_axi_rready) && n < 400);
    tmo(n);
  endtask
  task automatic rchk(input logic [7:0] a, m, e);
    logic [31:0] d;
    rd(a, d);
    chk(d & {24'h000000, m}, {24'h000000, e});
  endtask
  task automatic issue(input logic [15:0] c, input logic [47:0] l,
    input logic [7:0] dh, input logic [15:0] f, input logic [7:0] op,
    input logic [19:0] fi, input logic [3:0] fc);
    fault_idx <= fi;
    fault_code <= fc;
    mclr <= 1'b1;
    wr(`DRCE_OFF_FEATURE, f[15:8]);
    wr(`DRCE_OFF_FEATURE, f[7:0]);
    mclr <= 1'b0;
    wr(`DRCE_OFF_SECCNT, c[15:8]);
    wr(`DRCE_OFF_SECCNT, c[7:0]);
    wr(`DRCE_OFF_SECNUM, l[31:24]);
    wr(`DRCE_OFF_SECNUM, l[7:0]);
    wr(`DRCE_OFF_CYLLO, l[39:32]);
    wr(`DRCE_OFF_CYLLO, l[15:8]);
    wr(`DRCE_OFF_CYLHI, l[47:40]);
    wr(`DRCE_OFF_CYLHI, l[23:16]);
    wr(`DRCE_OFF_DEVHEAD, dh);
    wr(`DRCE_OFF_COMMAND, op);
  endtask
  // Words are taken only while the status offers one, until busy has ended and none is offered.
  task automatic drain(output int nw);
    logic [31:0] st;
    logic [31:0] d;
    int k;
    int bad;
    nw = 0;
    bad = 0;
    for (k = 0; k < 4000; k++)
    begin
      rd(`DRCE_OFF_STATUS, st);
      if (st[`DRCE_ST_DRQ] === 1'b1)
      begin
        rd(`DRCE_OFF_DATA, d);
        if (d[15:0] !== (16'h5A00 ^ nw[15:0])) bad++;
        nw++;
      end
      else if (st[`DRCE_ST_BSY] !== 1'b1) break;
    end
    tmo(k / 10);
    chk(bad, 0);
  endtask

  task automatic s_reset;
    logic [31:0] d;
    rchk(`DRCE_OFF_STATUS, 8'hFF, `DRCE_STATUS_RESET);
    rchk(`DRCE_OFF_ERROR, 8'hFF, 8'h00);
    rd(`DRCE_OFF_TIMEUNIT, d);
    chk(d, {16'h0000, `DRCE_TIMEUNIT_RESET});
    rd(8'h40, d);
    chk({30'h0, resp}, 32'h2);
    wr(8'h44, 8'h00);
    chk({30'h0, resp}, 32'h2);
    wr(`DRCE_OFF_COMMAND, 8'hFF);
    rchk(`DRCE_OFF_STATUS, 8'hFF, 8'h41);
    rchk(`DRCE_OFF_ERROR, 8'hFF, 8'h04);
  endtask
  task automatic s_read28;
    int i;
    int nw;
    for (i = 0; i < 2; i++)
    begin
      issue(16'h0001, 48'h000000456789, i ? 8'hA3 : 8'hE3, 16'h0000,
        `DRCE_CMD_READ | i[7:0], 20'hFFFFF, 4'h0);
      drain(nw);
      chk(nw, 256);
      rchk(`DRCE_OFF_STATUS, 8'h81, 8'h00);
      rchk(`DRCE_OFF_SECCNT, 8'hFF, 8'h00);
      rchk(`DRCE_OFF_SECNUM, 8'hFF, 8'h89);
      rchk(`DRCE_OFF_CYLLO, 8'hFF, 8'h67);
      rchk(`DRCE_OFF_CYLHI, 8'hFF, 8'h45);
      rchk(`DRCE_OFF_DEVHEAD, 8'h0F, 8'h03);
    end
  endtask
  task automatic s_ext_fail;
    int nw;
    slow <= 1'b1;
    issue(16'h0002, 48'hA1B2C3D4E5F0, 8'hE0, 16'h0000,
      `DRCE_CMD_READ_EXT, 20'd266, 4'h1);
    drain(nw);
    chk(nw, 266);
    rchk(`DRCE_OFF_STATUS, 8'h81, 8'h01);
    rchk(`DRCE_OFF_ERROR, 8'h40, 8'h40);
    rchk(`DRCE_OFF_SECCNT, 8'hFF, 8'h01);
    rchk(`DRCE_OFF_SECNUM, 8'hFF, 8'hF1);
    rchk(`DRCE_OFF_CYLLO, 8'hFF, 8'hE5);
    rchk(`DRCE_OFF_CYLHI, 8'hFF, 8'hD4);
    wr(`DRCE_OFF_CONTROL, 8'h80);
    rchk(`DRCE_OFF_SECCNT, 8'hFF, 8'h00);
    rchk(`DRCE_OFF_SECNUM, 8'hFF, 8'hC3);
    rchk(`DRCE_OFF_CYLLO, 8'hFF, 8'hB2);
    rchk(`DRCE_OFF_CYLHI, 8'hFF, 8'hA1);
    wr(`DRCE_OFF_CONTROL, 8'h00);
    slow <= 1'b0;
  endtask
  task automatic s_stream;
    logic [3:0] fc [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
    logic [7:0] eb [4] = '{8'h40, 8'h80, 8'h10, 8'h04};
    int i;
    int nw;
    for (i = 0; i < 4; i++)
    begin
      issue(16'h0001, 48'h0000000000A0, 8'hE0, 16'h0040,
        `DRCE_CMD_STREAM_DMA, 20'd9, fc[i]);
      drain(nw);
      chk(nw, 256);
      rchk(`DRCE_OFF_STATUS, 8'hA1, 8'h20);
      rchk(`DRCE_OFF_ERROR, 8'hD5, eb[i]);
      rchk(`DRCE_OFF_SECNUM, 8'hFF, 8'hA0);
      rchk(`DRCE_OFF_SECCNT, 8'hFF, 8'h01);
    end
    issue(16'h0001, 48'h0000000000B0, 8'hE0, 16'h0000,
      `DRCE_CMD_STREAM_DMA, 20'd5, 4'h2);
    drain(nw);
    chk(nw, 5);
    rchk(`DRCE_OFF_STATUS, 8'hA1, 8'h01);
    rchk(`DRCE_OFF_ERROR, 8'hD5, 8'h80);
    // One microsecond limit with a zero count: the run must end by expiry.
    issue(16'h0000, 48'h000000000000, 8'hE0, 16'h0140,
      `DRCE_CMD_STREAM_DMA, 20'hFFFFF, 4'h0);
    drain(nw);
    chk(nw > 0 && nw < 256, 32'h1);
    rchk(`DRCE_OFF_STATUS, 8'hA1, 8'h20);
    rchk(`DRCE_OFF_ERROR, 8'hD5, 8'h01);
  endtask

  initial
  begin
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
    s_reset;
    s_read28;
    s_ext_fail;
    s_stream;
    wrap_up;
  end
endmodule
